// ==== design/hwr_pkg.sv ====
// hwr_pkg: constants and types for the halt/wake-up/reset sequencer.
// assumes a 100 MHz system clock and an 8-bit port A.
package hwr_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned STARTUP_SYSTEM_CLOCK_PERIOD     = 1024;
  // counts are in system clock periods, one clock each
  localparam int unsigned STARTUP_CYCLES   = STARTUP_SYSTEM_CLOCK_PERIOD * (CLK_MHZ / CLK_MHZ);
  localparam int unsigned CNT_W            = 11;
  localparam logic [10:0] STARTUP_LAST     = 11'(STARTUP_CYCLES - 1);
  localparam int unsigned PORTA_W          = 8;
  localparam logic [7:0]  PORTA_WAKE_RST   = 8'hFF;
  localparam int unsigned WDT_W            = 8;
  localparam logic [7:0]  WDT_RST          = 8'h00;
  localparam int unsigned PRE_W            = 7;
  localparam logic [6:0]  PRE_RST          = 7'h00;
  localparam logic [2:0]  WDT_SEL_RST      = 3'h7;
  localparam int unsigned PC_W             = 16;
  localparam logic [15:0] PC_RST           = 16'h0000;
  localparam int unsigned SP_W             = 3;
  localparam logic [2:0]  SP_TOP           = 3'h0;
  localparam logic [7:0]  PORT_DIR_INPUT   = 8'hFF;

  typedef enum logic [2:0] {
    HWR_ST_STARTUP = 3'b000,
    HWR_ST_RUN     = 3'b001,
    HWR_ST_HALT    = 3'b011,
    HWR_ST_DUMMY   = 3'b010,
    HWR_ST_INTDLY  = 3'b110
  } hwr_state_type;

  typedef enum logic [1:0] {
    HWR_RS_NONE    = 2'h0,
    HWR_RS_NEXT    = 2'h1,
    HWR_RS_INT     = 2'h2,
    HWR_RS_WARM    = 2'h3
  } hwr_resume_type;
endpackage : hwr_pkg

// ==== design/hwr_wdt_if.sv ====
// hwr_wdt_if: signals between the sequencer and its watchdog counter.
// assumes both ends share the system clock.
`timescale 1ns/1ps
interface hwr_wdt_if;
  logic       clear;
  logic [2:0] sel;
  logic       enable;
  logic       overflow;
  modport ctrl (output clear, output sel, output enable, input overflow);
  modport cnt  (input clear, input sel, input enable, output overflow);
endinterface : hwr_wdt_if

// ==== design/hwr_wdt.sv ====
// hwr_wdt: watchdog prescaler and counter, one overflow pulse per wrap.
// assumes i_tick is a synchronous one-cycle count enable.
`timescale 1ns/1ps
module hwr_wdt (
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic       i_tick,
  hwr_wdt_if.cnt          wdt
);
  logic [hwr_pkg::PRE_W-1:0] pre_reg;
  logic [hwr_pkg::WDT_W-1:0] cnt_reg;
  logic                      ovf_reg;
  logic                      pre_done;

  // prescaler tap chosen by sel: ratio 1:2^sel
  always_comb begin
    pre_done = 1'b1;
    if (wdt.sel != 3'h0) begin
      pre_done = &pre_reg[wdt.sel - 3'h1 -: 1] & (pre_reg & ((7'h01 << wdt.sel) - 7'h01)) ==
                 ((7'h01 << wdt.sel) - 7'h01);
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_reg <= hwr_pkg::PRE_RST;
      cnt_reg <= hwr_pkg::WDT_RST;
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= 1'b0;
      if (wdt.clear || !wdt.enable) begin
        pre_reg <= hwr_pkg::PRE_RST;
        cnt_reg <= hwr_pkg::WDT_RST;
      end else if (i_tick) begin
        pre_reg <= pre_done ? hwr_pkg::PRE_RST : pre_reg + 7'h01;
        if (pre_done) begin
          cnt_reg <= cnt_reg + 8'h01;
          ovf_reg <= &cnt_reg;
        end
      end
    end
  end

  assign wdt.overflow = ovf_reg;
endmodule : hwr_wdt

// ==== design/hwr_sync.sv ====
// hwr_sync: two-flop synchroniser for a vector of pin levels.
// assumes inputs are asynchronous to i_mclk.
`timescale 1ns/1ps
module hwr_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  // pins idle high, so reset to high avoids a false falling edge
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule : hwr_sync

// ==== design/hwr_seq.sv ====
// hwr_seq: halt entry, wake-up, start-up delay and reset-cause flags.
// assumes the core pulses halt/clear-watchdog for one cycle and stalls while o_stall is high.
`timescale 1ns/1ps
module hwr_seq #(
  parameter logic [7:0] PORTA_WAKE_EN = hwr_pkg::PORTA_WAKE_RST
) (
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic       i_power_on,
  input  wire logic       i_external_reset_pin_n,
  input  wire logic       i_halt_instr,
  input  wire logic       i_watchdog_clear_instr,
  input  wire logic [7:0] i_int_req,
  input  wire logic [7:0] i_int_en,
  input  wire logic       i_int_master_en,
  input  wire logic       i_stack_full,
  input  wire logic [7:0] i_porta,
  input  wire logic       i_wdt_osc_sel,
  input  wire logic       i_wdt_osc_tick,
  input  wire logic       i_wdt_enable,
  input  wire logic [2:0] i_wdt_sel,
  output logic            o_sys_clk_en,
  output logic            o_stall,
  output logic            o_chip_reset,
  output logic            o_warm_reset,
  output logic            o_int_ack_en,
  output logic            o_hold_state,
  output logic [15:0]     o_pc_reset_val,
  output logic [2:0]      o_stack_pointer_reset_val,
  output logic [7:0]      o_port_dir_reset_val,
  output logic            o_timeout_cause_flag,
  output logic            o_powerdown_cause_flag
);
  hwr_wdt_if wdt_bus ();

  hwr_pkg::hwr_state_type  state_reg;
  hwr_pkg::hwr_resume_type resume_reg;
  logic [hwr_pkg::CNT_W-1:0] startup_delay_timer_reg;
  logic [7:0] porta_s;
  logic [0:0] rst_pin_s;
  logic [7:0] porta_prev_reg;
  logic [7:0] int_mask_reg;
  logic       timeout_cause_flag_reg;
  logic       powerdown_cause_flag_reg;
  logic       sys_clk_en_reg;
  logic       stall_reg;
  logic       chip_reset_reg;
  logic       warm_reset_reg;
  logic       int_ack_en_reg;
  logic       hold_reg;
  logic       wdt_clear_reg;
  logic       rst_pin_prev_reg;
  logic       rst_fall;
  logic       porta_wake;
  logic       int_wake;
  logic       int_serve;
  logic       wdt_tick;
  logic       halt_take;
  logic [15:0] pc_reset_val_reg;
  logic [2:0]  sp_reset_val_reg;
  logic [7:0]  dir_reset_val_reg;

  // halt counts only in run; power-up or a low reset pin on the same edge overrides it
  function automatic logic halt_accepted(input hwr_pkg::hwr_state_type st, input logic halt,
                                         input logic pwr, input logic pin_n);
    return st == hwr_pkg::HWR_ST_RUN && halt && !pwr && pin_n;
  endfunction : halt_accepted

  hwr_sync #(.W(8)) u_porta_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_async  (i_porta),
    .o_sync   (porta_s)
  );

  hwr_sync #(.W(1)) u_rst_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_async  (i_external_reset_pin_n),
    .o_sync   (rst_pin_s)
  );

  // watchdog counts i_wdt_osc_tick outside halt; in halt only while i_wdt_osc_sel selects its own oscillator
  assign wdt_tick = (state_reg == hwr_pkg::HWR_ST_HALT) ? i_wdt_osc_sel && i_wdt_osc_tick : i_wdt_osc_tick;

  hwr_wdt u_wdt (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_tick   (wdt_tick),
    .wdt      (wdt_bus.cnt)
  );

  assign wdt_bus.clear  = wdt_clear_reg;
  assign wdt_bus.sel    = i_wdt_sel;
  assign wdt_bus.enable = i_wdt_enable;

  assign rst_fall   = rst_pin_prev_reg && !rst_pin_s[0];
  assign porta_wake = |(porta_prev_reg & ~porta_s & PORTA_WAKE_EN);
  assign int_wake   = |(i_int_req & ~int_mask_reg);
  assign int_serve  = |(i_int_req & ~int_mask_reg & i_int_en) && i_int_master_en && !i_stack_full;
  assign halt_take  = halt_accepted(state_reg, i_halt_instr, i_power_on, rst_pin_s[0]);

  // edge history resets to the idle-high pin level, so reset gives no false fall
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      porta_prev_reg <= hwr_pkg::PORTA_WAKE_RST;
    end else begin
      porta_prev_reg <= porta_s;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_pin_prev_reg <= 1'b1;
    end else begin
      rst_pin_prev_reg <= rst_pin_s[0];
    end
  end

  // pending requests at halt entry are masked out of the wake logic
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_mask_reg <= 8'h00;
    end else if (halt_take) begin
      int_mask_reg <= i_int_req;
    end else if (state_reg == hwr_pkg::HWR_ST_RUN) begin
      int_mask_reg <= 8'h00;
    end
  end

  // main sequence; external reset is treated as a synchronous event
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg               <= hwr_pkg::HWR_ST_STARTUP;
      resume_reg              <= hwr_pkg::HWR_RS_NONE;
      startup_delay_timer_reg <= '0;
    end else if (i_power_on) begin
      state_reg               <= hwr_pkg::HWR_ST_STARTUP;
      resume_reg              <= hwr_pkg::HWR_RS_NONE;
      startup_delay_timer_reg <= '0;
    end else if (!rst_pin_s[0]) begin
      // no start-up delay after the reset pin
      state_reg               <= hwr_pkg::HWR_ST_RUN;
      resume_reg              <= hwr_pkg::HWR_RS_NONE;
      startup_delay_timer_reg <= '0;
    end else begin
      case (state_reg)
        hwr_pkg::HWR_ST_STARTUP: begin
          startup_delay_timer_reg <= startup_delay_timer_reg + 11'h001;
          if (startup_delay_timer_reg == hwr_pkg::STARTUP_LAST) begin
            state_reg <= hwr_pkg::HWR_ST_RUN;
          end
        end
        hwr_pkg::HWR_ST_RUN: begin
          if (halt_take) begin
            state_reg <= hwr_pkg::HWR_ST_HALT;
          end
        end
        hwr_pkg::HWR_ST_HALT: begin
          startup_delay_timer_reg <= '0;
          if (wdt_bus.overflow) begin
            state_reg  <= hwr_pkg::HWR_ST_DUMMY;
            resume_reg <= hwr_pkg::HWR_RS_WARM;
          end else if (int_wake) begin
            state_reg  <= hwr_pkg::HWR_ST_DUMMY;
            resume_reg <= int_serve ? hwr_pkg::HWR_RS_INT : hwr_pkg::HWR_RS_NEXT;
          end else if (porta_wake) begin
            state_reg  <= hwr_pkg::HWR_ST_DUMMY;
            resume_reg <= hwr_pkg::HWR_RS_NEXT;
          end
        end
        hwr_pkg::HWR_ST_DUMMY: begin
          startup_delay_timer_reg <= startup_delay_timer_reg + 11'h001;
          if (startup_delay_timer_reg == hwr_pkg::STARTUP_LAST) begin
            state_reg <= (resume_reg == hwr_pkg::HWR_RS_INT) ? hwr_pkg::HWR_ST_INTDLY : hwr_pkg::HWR_ST_RUN;
          end
        end
        hwr_pkg::HWR_ST_INTDLY: begin
          state_reg <= hwr_pkg::HWR_ST_RUN;
        end
        default: begin
          state_reg <= hwr_pkg::HWR_ST_STARTUP;
        end
      endcase
    end
  end

  // watchdog clear: reset pin low, clear instruction, halt entry, power-up, chip reset
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wdt_clear_reg <= 1'b1;
    end else begin
      wdt_clear_reg <= i_power_on || !rst_pin_s[0] || i_watchdog_clear_instr || halt_take ||
                       chip_reset_reg;
    end
  end

  // timeout cause; a watchdog set wins over a halt-entry clear on the same edge
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      timeout_cause_flag_reg <= 1'b0;
    end else if (i_power_on) begin
      timeout_cause_flag_reg <= 1'b0;
    end else if (state_reg == hwr_pkg::HWR_ST_HALT && rst_fall) begin
      timeout_cause_flag_reg <= 1'b0;
    end else if (wdt_bus.overflow && state_reg != hwr_pkg::HWR_ST_STARTUP && rst_pin_s[0]) begin
      timeout_cause_flag_reg <= 1'b1;
    end else if (halt_take) begin
      timeout_cause_flag_reg <= 1'b0;
    end
  end

  // powerdown cause; kept apart so a watchdog event cannot block its clear
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      powerdown_cause_flag_reg <= 1'b0;
    end else if (i_power_on) begin
      powerdown_cause_flag_reg <= 1'b0;
    end else if (state_reg == hwr_pkg::HWR_ST_HALT && rst_fall) begin
      powerdown_cause_flag_reg <= 1'b1;
    end else if (halt_take) begin
      powerdown_cause_flag_reg <= 1'b1;
    end else if (state_reg == hwr_pkg::HWR_ST_RUN && i_watchdog_clear_instr) begin
      powerdown_cause_flag_reg <= 1'b0;
    end
  end

  // clock gated from the halt edge on; the sequencer keeps running for wake detection
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sys_clk_en_reg <= 1'b1;
    end else begin
      sys_clk_en_reg <= !(state_reg == hwr_pkg::HWR_ST_HALT || halt_take);
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= state_reg == hwr_pkg::HWR_ST_HALT || halt_take;
    end
  end

  // stall on the halt edge too, so no fetch slips in behind the halt
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stall_reg <= 1'b1;
    end else begin
      stall_reg <= state_reg != hwr_pkg::HWR_ST_RUN || halt_take;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chip_reset_reg <= 1'b1;
    end else begin
      chip_reset_reg <= i_power_on || !rst_pin_s[0] ||
                        (wdt_bus.overflow && state_reg == hwr_pkg::HWR_ST_RUN) ||
                        state_reg == hwr_pkg::HWR_ST_STARTUP;
    end
  end

  // warm reset only when no stronger reset lands on the same edge
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      warm_reset_reg <= 1'b0;
    end else begin
      warm_reset_reg <= state_reg == hwr_pkg::HWR_ST_HALT && wdt_bus.overflow &&
                        rst_pin_s[0] && !i_power_on;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_ack_en_reg <= 1'b0;
    end else begin
      int_ack_en_reg <= state_reg == hwr_pkg::HWR_ST_INTDLY;
    end
  end

  // reset values for the core, kept in flops so every output is registered
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pc_reset_val_reg  <= hwr_pkg::PC_RST;
      sp_reset_val_reg  <= hwr_pkg::SP_TOP;
      dir_reset_val_reg <= hwr_pkg::PORT_DIR_INPUT;
    end else begin
      pc_reset_val_reg  <= hwr_pkg::PC_RST;
      sp_reset_val_reg  <= hwr_pkg::SP_TOP;
      dir_reset_val_reg <= hwr_pkg::PORT_DIR_INPUT;
    end
  end

  assign o_sys_clk_en              = sys_clk_en_reg;
  assign o_stall                   = stall_reg;
  assign o_chip_reset              = chip_reset_reg;
  assign o_warm_reset              = warm_reset_reg;
  assign o_int_ack_en              = int_ack_en_reg;
  assign o_hold_state              = hold_reg;
  assign o_pc_reset_val            = pc_reset_val_reg;
  assign o_stack_pointer_reset_val = sp_reset_val_reg;
  assign o_port_dir_reset_val      = dir_reset_val_reg;
  assign o_timeout_cause_flag      = timeout_cause_flag_reg;
  assign o_powerdown_cause_flag    = powerdown_cause_flag_reg;
endmodule : hwr_seq

// ==== testbench/hwr_seq_sva.sv ====
// hwr_seq_sva: port assertions for the halt/wake sequencer.
// assumes binding onto hwr_seq; one clock domain.
`timescale 1ns/1ps
module hwr_seq_sva (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_power_on,
  input wire logic i_halt_instr,
  input wire logic i_watchdog_clear_instr,
  input wire logic i_wdt_enable,
  input wire logic o_sys_clk_en,
  input wire logic o_stall,
  input wire logic o_chip_reset,
  input wire logic o_warm_reset,
  input wire logic o_int_ack_en,
  input wire logic o_hold_state,
  input wire logic o_timeout_cause_flag,
  input wire logic o_powerdown_cause_flag
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  logic [11:0] cnt_reg;
  logic        armed_reg;
  logic        run_go;
  assign run_go = i_halt_instr && !o_stall && !i_power_on;
  // stall cycles after halt; pin resets skip the delay, so disarm
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg   <= 12'h000;
      armed_reg <= 1'b0;
    end else if (o_hold_state) begin
      cnt_reg   <= 12'h000;
      armed_reg <= !o_chip_reset;
    end else if (o_chip_reset || !o_stall) begin
      armed_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end
  property p_halt_enter;
    run_go |=> o_hold_state && !o_sys_clk_en;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not entered");
  property p_halt_flags;
    run_go && !i_wdt_enable |=> o_powerdown_cause_flag && !o_timeout_cause_flag;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
  property p_hold_stall;
    o_hold_state |-> o_stall && !o_sys_clk_en;
  endproperty
  a_hold_stall: assert property (p_hold_stall) else $error("halt not holding");
  property p_pd_clear;
    i_watchdog_clear_instr && !run_go && !o_stall && !i_power_on |=> !o_powerdown_cause_flag;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("powerdown flag not cleared");
  property p_warm_flags;
    o_warm_reset |-> ##[0:1] (o_timeout_cause_flag && o_powerdown_cause_flag);
  endproperty
  a_warm_flags: assert property (p_warm_flags) else $error("warm reset flags wrong");
  property p_warm_pulse;
    o_warm_reset |-> !o_chip_reset ##1 !o_warm_reset;
  endproperty
  a_warm_pulse: assert property (p_warm_pulse) else $error("warm reset not a lone pulse");
  property p_ack_pulse;
    o_int_ack_en |-> !o_hold_state ##1 !o_int_ack_en;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack pulse wrong");
  property p_dummy_len;
    $fell(o_stall) && armed_reg |-> cnt_reg >= 12'h3FF && cnt_reg <= 12'h404;
  endproperty
  a_dummy_len: assert property (p_dummy_len) else $error("dummy period length wrong");
endmodule : hwr_seq_sva
bind hwr_seq hwr_seq_sva u_hwr_seq_sva (.i_mclk, .i_arst_n, .i_power_on, .i_halt_instr, .i_watchdog_clear_instr,
  .i_wdt_enable, .o_sys_clk_en, .o_stall, .o_chip_reset, .o_warm_reset, .o_int_ack_en, .o_hold_state,
  .o_timeout_cause_flag, .o_powerdown_cause_flag);

// ==== testbench/hwr_core_model.sv ====
// hwr_core_model: core stand-in giving halt and clear pulses.
// assumes requests are held until the pulse is seen.
`timescale 1ns/1ps
module hwr_core_model (
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_stall,
  input  wire logic i_halt_req,
  input  wire logic i_clr_req,
  output logic      o_halt_instr,
  output logic      o_watchdog_clear_instr
);
  // no fetch while stalled, so nothing issues then
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_halt_instr           <= 1'b0;
      o_watchdog_clear_instr <= 1'b0;
    end else begin
      o_halt_instr           <= i_halt_req && !i_stall && !o_halt_instr;
      o_watchdog_clear_instr <= i_clr_req && !i_stall && !o_watchdog_clear_instr;
    end
  end
endmodule : hwr_core_model

// ==== testbench/testbench.sv ====
// testbench: self-checking bench for hwr_seq with a core stand-in.
// assumes port A bit 7 has no wake; watchdog tick held high.
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [7:0] pa;
    logic [7:0] irq;
    logic [7:0] ien;
    logic       mst;
    logic       full;
    logic       ack;
  } hwr_row_type;
  hwr_row_type rows [7] = '{'{8'hFE, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0}, '{8'hBF, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0},
    '{8'hFF, 8'h04, 8'h04, 1'b1, 1'b0, 1'b1}, '{8'hFF, 8'h04, 8'h00, 1'b1, 1'b0, 1'b0},
    '{8'hFF, 8'h04, 8'h04, 1'b1, 1'b1, 1'b0}, '{8'hFF, 8'h04, 8'h04, 1'b0, 1'b0, 1'b0},
    '{8'hFF, 8'h80, 8'h80, 1'b1, 1'b0, 1'b1}};
  logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b0, pin_n = 1'b1, hreq = 1'b0, creq = 1'b0;
  logic mst = 1'b0, full = 1'b0, osel = 1'b1, tick = 1'b1, wen = 1'b0;
  logic [7:0] ireq = 8'h00, ien = 8'h00, pa = 8'hFF;
  logic [2:0] wsel = 3'h0;
  logic halt, clr, clk_en, stall, chip, warm, ack, hold, to_f, pd_f, acks, warms;
  logic [15:0] pcv;
  logic [2:0] spv;
  logic [7:0] dirv;
  logic [4:0] ev;
  int failures = 0, check_count = 0, n, t1;
  assign ev = {clr, halt, chip, warm, !stall};
  always #5 clk = ~clk;
  hwr_core_model u_hwr_core_model (.i_mclk(clk), .i_arst_n(rst_n), .i_stall(stall), .i_halt_req(hreq),
    .i_clr_req(creq), .o_halt_instr(halt), .o_watchdog_clear_instr(clr));
  hwr_seq #(.PORTA_WAKE_EN(8'h7F)) u_hwr_seq (.i_mclk(clk), .i_arst_n(rst_n), .i_power_on(pwr),
    .i_external_reset_pin_n(pin_n), .i_halt_instr(halt), .i_watchdog_clear_instr(clr), .i_int_req(ireq),
    .i_int_en(ien), .i_int_master_en(mst), .i_stack_full(full), .i_porta(pa), .i_wdt_osc_sel(osel),
    .i_wdt_osc_tick(tick), .i_wdt_enable(wen), .i_wdt_sel(wsel), .o_sys_clk_en(clk_en), .o_stall(stall),
    .o_chip_reset(chip), .o_warm_reset(warm), .o_int_ack_en(ack), .o_hold_state(hold),
    .o_pc_reset_val(pcv), .o_stack_pointer_reset_val(spv), .o_port_dir_reset_val(dirv),
    .o_timeout_cause_flag(to_f), .o_powerdown_cause_flag(pd_f));
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // events: 0 run, 1 warm, 2 chip, 3 halt pulse, 4 clear pulse
  task automatic wait_for(input int m);
    n = 0;
    acks = 1'b0;
    warms = 1'b0;
    while (ev[m] !== 1'b1) begin
      cyc(1);
      n++;
      acks |= ack;
      warms |= warm;
      if (n > 40000) begin
        failures++;
        give_verdict();
      end
    end
  endtask : wait_for
  task automatic core_op(input logic h);
    hreq = h;
    creq = !h;
    wait_for(h ? 3 : 4);
    hreq = 1'b0;
    creq = 1'b0;
  endtask : core_op
  initial begin
    cyc(12);
    check("stall_rst", 16'h1, 16'(stall));
    check("flags_rst", 16'h0, 16'({to_f, pd_f}));
    check("pc_rst", 16'h0000, pcv);
    check("sp_rst", 16'h0, 16'(spv));
    check("dir_rst", 16'h00FF, 16'(dirv));
    rst_n = 1'b1;
    wait_for(0);
    check("startup", 16'h1, 16'(n >= 1023 && n <= 1028));
    foreach (rows[i]) begin
      ien = rows[i].ien;
      mst = rows[i].mst;
      full = rows[i].full;
      core_op(1'b1);
      cyc(3);
      check("hold", 16'h1, 16'(hold));
      check("clk_en", 16'h0, 16'(clk_en));
      check("flags_halt", 16'h1, 16'({to_f, pd_f}));
      pa = rows[i].pa;
      ireq = rows[i].irq;
      wait_for(0);
      check("dummy", 16'h1, 16'(n >= 1024 && n <= 1034));
      check("ack", 16'(rows[i].ack), 16'(acks));
      check("warm", 16'h0, 16'(warms));
      pa = 8'hFF;
      ireq = 8'h00;
      cyc(2);
    end
    // request pending before halt, and a masked-off pin
    ien = 8'h04;
    ireq = 8'h04;
    core_op(1'b1);
    pa = 8'h7F;
    cyc(40);
    check("no_wake", 16'h1, 16'(hold));
    pa = 8'h7D;
    wait_for(0);
    check("pa_wake", 16'h1, 16'(n >= 1024 && n <= 1034));
    pa = 8'hFF;
    ireq = 8'h00;
    wen = 1'b1;
    core_op(1'b0);
    core_op(1'b1);
    wait_for(1);
    t1 = n;
    wen = 1'b0;
    wait_for(0);
    check("flags_wdt", 16'h3, 16'({to_f, pd_f}));
    // a nearly expired watchdog must restart from zero at halt
    wen = 1'b1;
    core_op(1'b0);
    cyc(t1 - 8);
    core_op(1'b1);
    wait_for(1);
    wen = 1'b0;
    check("wdt_restart", 16'h1, 16'(n >= t1 - 4 && n <= t1 + 4));
    wait_for(0);
    wen = 1'b1;
    wait_for(2);
    wen = 1'b0;
    cyc(2);
    check("to_run", 16'h3, 16'({to_f, pd_f}));
    wait_for(0);
    core_op(1'b0);
    cyc(1);
    check("pd_clr", 16'h2, 16'({to_f, pd_f}));
    pin_n = 1'b0;
    cyc(6);
    check("pin_chip", 16'h1, 16'(chip));
    pin_n = 1'b1;
    cyc(4);
    check("pin_free", 16'h0, 16'(chip));
    wait_for(0);
    check("flags_pin", 16'h2, 16'({to_f, pd_f}));
    core_op(1'b1);
    cyc(3);
    pin_n = 1'b0;
    cyc(6);
    pin_n = 1'b1;
    cyc(4);
    wait_for(0);
    check("pin_wake", 16'h1, 16'(n <= 100));
    check("pin_hold", 16'h0, 16'(hold));
    check("flags_pinh", 16'h1, 16'({to_f, pd_f}));
    // watchdog on the system clock must stand still in halt
    osel = 1'b0;
    wen = 1'b1;
    core_op(1'b1);
    cyc(300);
    check("wdt_frozen", 16'h1, 16'(hold));
    wen = 1'b0;
    pa = 8'hFE;
    wait_for(0);
    check("frozen_to", 16'h0, 16'(to_f));
    pa = 8'hFF;
    osel = 1'b1;
    cyc(2);
    pwr = 1'b1;
    cyc(1);
    pwr = 1'b0;
    cyc(2);
    wait_for(0);
    check("power_up", 16'h1, 16'(n >= 1018 && n <= 1030));
    check("flags_pwr", 16'h0, 16'({to_f, pd_f}));
    give_verdict();
  end
endmodule : testbench
